// ### logic/tcc_pin_sync.sv
// Two-flop synchroniser with edge detection for asynchronous timer pins.
`default_nettype none

module tcc_pin_sync #(
    parameter int unsigned WIDTH = 14
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] sync_q;

    // The edge detector compares the second stage with a third flop, never with the first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync <= '0;
            sync_q <= '0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            sync_q <= sync;
        end
    end

    assign rise_o = sync & ~sync_q;
    assign fall_o = ~sync & sync_q;

endmodule : tcc_pin_sync

`default_nettype wire

// ### logic/tcc_pkg.sv
// Shared constants, field layouts and carrier types for the timer compare/capture block.
`default_nettype none

package tcc_pkg;

    // Channel arrangement.
    localparam int unsigned TCC_CHANNELS = 5;
    localparam int unsigned TCC_BUF_FIRST = 3;
    localparam int unsigned TCC_PHASE_CHANNEL = 2;
    localparam int unsigned TCC_WIDTH = 16;

    // Register index within a channel; the channel number forms address bits 5:3.
    localparam logic [2:0] TCC_OFS_CONTROL = 3'h0;
    localparam logic [2:0] TCC_OFS_COUNTER = 3'h1;
    localparam logic [2:0] TCC_OFS_CC_A = 3'h2;
    localparam logic [2:0] TCC_OFS_CC_B = 3'h3;
    localparam logic [2:0] TCC_OFS_SB_A = 3'h4;
    localparam logic [2:0] TCC_OFS_SB_B = 3'h5;

    // Reset values, also loaded on entry to standby.
    localparam logic [15:0] TCC_CC_RESET = 16'hffff;
    localparam logic [15:0] TCC_SB_RESET = 16'hffff;
    localparam logic [15:0] TCC_COUNTER_RESET = 16'h0000;
    localparam logic [7:0] TCC_CONTROL_RESET = 8'h80;
    localparam logic [2:0] TCC_FS_RESET = 3'h0;

    // Counter control field positions.
    localparam int unsigned TCC_CTRL_RSVD_BIT = 7;
    localparam int unsigned TCC_CTRL_CLEAR_HI = 6;
    localparam int unsigned TCC_CTRL_CLEAR_LO = 5;
    localparam int unsigned TCC_CTRL_EDGE_HI = 4;
    localparam int unsigned TCC_CTRL_EDGE_LO = 3;
    localparam int unsigned TCC_CTRL_CLKSEL_HI = 2;
    localparam int unsigned TCC_CTRL_CLKSEL_LO = 0;

    // Function select field: bit 2 picks capture, bits 1:0 the capture edge.
    localparam int unsigned TCC_FS_CAPTURE_BIT = 2;

    // Buffer enable positions in the function control input.
    localparam int unsigned TCC_BUF_EN_A3 = 0;
    localparam int unsigned TCC_BUF_EN_B3 = 1;
    localparam int unsigned TCC_BUF_EN_A4 = 2;
    localparam int unsigned TCC_BUF_EN_B4 = 3;

    typedef enum logic [1:0] {
        TCC_CLR_NONE = 2'b00,
        TCC_CLR_A = 2'b01,
        TCC_CLR_B = 2'b10,
        TCC_CLR_SYNC = 2'b11
    } tcc_clear_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } tcc_bus_req_t;

    typedef struct packed {
        logic [2:0] function_select_b;
        logic [2:0] function_select_a;
        logic pwm_mode;
        logic sync_clear;
        logic count_start;
    } tcc_chan_cfg_t;

endpackage : tcc_pkg

`default_nettype wire

// ### logic/tcc_prescale.sv
// Free-running divider giving one-cycle ticks at the falling edges of clk/1, /2, /4, /8.
`default_nettype none

module tcc_prescale #(
    parameter int unsigned STAGES = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [STAGES:0] tick_o
);

    logic [STAGES-1:0] div;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // A divided clock falls when every lower divider bit is about to wrap.
    assign tick_o[0] = 1'b1;
    for (genvar k = 1; k <= STAGES; k++) begin : g_tick
        assign tick_o[k] = &div[k-1:0];
    end

endmodule : tcc_prescale

`default_nettype wire

// ### logic/tcc_timer.sv
// Five-channel 16-bit timer: counters, compare/capture registers, buffers and control.
`default_nettype none

// Notes on behaviour
// - Two 16-bit compare/capture registers per channel.
// - Compare mode: equality sets the matching flag.
// - Capture mode: selected edge latches counter, sets flag.
// - PWM modes override compare/capture function selection.
// - Registers accessible by word or byte.
// - Reset/standby: all ones, output compare, no action.
// - Buffer registers exist only in channels 3, 4.
// - Buffered compare: buffer copies in at match.
// - Buffered capture: old value moves to buffer.
// - Four independent buffer enable bits.
// - Buffer registers reset to all ones.
// - Control register resets 0x80; bit 7 fixed one.
// - Clear field picks none, A, B or sync.
// - Clear follows match or capture per register use.
// - Edge field: rising, falling or both edges.
// - Clock select: clk, /2, /4, /8, pins A-D.
// - Internal clocks count falling edges; external per field.
// - Channel 2 phase counting overrides clock fields.
// - A or B clear event zeroes the counter.
module tcc_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire tcc_pkg::tcc_bus_req_t bus_req_i,
    output logic [15:0] bus_rdata_o,
    input wire tcc_pkg::tcc_chan_cfg_t [4:0] chan_cfg_i,
    input wire logic [3:0] function_control_i,
    input wire logic phase_count_enable_i,
    input wire logic phase_step_i,
    input wire logic phase_up_i,
    input wire logic ext_clock_in_a_i,
    input wire logic ext_clock_in_b_i,
    input wire logic ext_clock_in_c_i,
    input wire logic ext_clock_in_d_i,
    input wire logic [4:0] capture_in_a_i,
    input wire logic [4:0] capture_in_b_i,
    input wire logic [4:0] flag_clear_a_i,
    input wire logic [4:0] flag_clear_b_i,
    output logic [4:0] match_capture_flag_a_o,
    output logic [4:0] match_capture_flag_b_o
);

    localparam int unsigned NCH = tcc_pkg::TCC_CHANNELS;
    localparam int unsigned NPIN = 14;

    // Reset and standby both return every timer register to its initial value; the pin synchroniser and read data register reset on rst_i alone.
    logic init;
    assign init = rst_i | standby_i;

    // Pin order: clocks A-D in bits 3:0, capture A in 8:4, capture B in 13:9.
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;
    logic [3:0] ext_rise;
    logic [3:0] ext_fall;
    logic [3:0] int_tick;

    tcc_pin_sync #(
        .WIDTH(NPIN)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({capture_in_b_i, capture_in_a_i, ext_clock_in_d_i, ext_clock_in_c_i,
                ext_clock_in_b_i, ext_clock_in_a_i}),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    tcc_prescale #(
        .STAGES(3)
    ) u_prescale (
        .clk_i(clk_i),
        .rst_i(init),
        .tick_o(int_tick)
    );

    assign ext_rise = pin_rise[3:0];
    assign ext_fall = pin_fall[3:0];

    // Merges a bus write into a 16-bit register, one byte lane at a time.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge16

    // Capture edge decode shared by both registers of a channel.
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                      input logic fall);
        logic hit;
        hit = sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
        return hit;
    endfunction : edge_hit

    logic [15:0] counter_w [NCH];
    logic [15:0] cc_a_w [NCH];
    logic [15:0] cc_b_w [NCH];
    logic [15:0] sb_a_w [NCH];
    logic [15:0] sb_b_w [NCH];
    logic [6:0] control_w [NCH];
    logic [4:0] flag_a;
    logic [4:0] flag_b;

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        localparam logic [2:0] CH = 3'(ch);

        logic [6:0] control;
        logic [15:0] counter;
        logic [15:0] cc_a;
        logic [15:0] cc_b;
        logic [15:0] sb_a_q;
        logic [15:0] sb_b_q;
        logic sel;
        logic wr_ctrl;
        logic wr_cnt;
        logic wr_a;
        logic wr_b;
        logic cap_mode_a;
        logic cap_mode_b;
        logic cap_evt_a;
        logic cap_evt_b;
        logic cmp_evt_a;
        logic cmp_evt_b;
        logic evt_a;
        logic evt_b;
        logic buf_en_a;
        logic buf_en_b;
        logic clk_tick;
        logic phase_mode;
        logic count_tick;
        logic clear;
        tcc_pkg::tcc_clear_t clr_src;
        logic [2:0] clk_sel;
        logic [1:0] edge_sel;

        assign sel = bus_req_i.wr && (bus_req_i.addr[5:3] == CH);
        assign wr_ctrl = sel && (bus_req_i.addr[2:0] == tcc_pkg::TCC_OFS_CONTROL);
        assign wr_cnt = sel && (bus_req_i.addr[2:0] == tcc_pkg::TCC_OFS_COUNTER);
        assign wr_a = sel && (bus_req_i.addr[2:0] == tcc_pkg::TCC_OFS_CC_A);
        assign wr_b = sel && (bus_req_i.addr[2:0] == tcc_pkg::TCC_OFS_CC_B);

        assign clr_src = tcc_pkg::tcc_clear_t'(
            control[tcc_pkg::TCC_CTRL_CLEAR_HI:tcc_pkg::TCC_CTRL_CLEAR_LO]);
        assign edge_sel = control[tcc_pkg::TCC_CTRL_EDGE_HI:tcc_pkg::TCC_CTRL_EDGE_LO];
        assign clk_sel = control[tcc_pkg::TCC_CTRL_CLKSEL_HI:tcc_pkg::TCC_CTRL_CLKSEL_LO];

        // In the PWM modes the function selection is ignored and both registers compare.
        assign cap_mode_a = chan_cfg_i[ch].function_select_a[tcc_pkg::TCC_FS_CAPTURE_BIT]
                            && !chan_cfg_i[ch].pwm_mode;
        assign cap_mode_b = chan_cfg_i[ch].function_select_b[tcc_pkg::TCC_FS_CAPTURE_BIT]
                            && !chan_cfg_i[ch].pwm_mode;

        assign cap_evt_a = cap_mode_a && edge_hit(chan_cfg_i[ch].function_select_a[1:0],
                                                  pin_rise[4+ch], pin_fall[4+ch]);
        assign cap_evt_b = cap_mode_b && edge_hit(chan_cfg_i[ch].function_select_b[1:0],
                                                  pin_rise[9+ch], pin_fall[9+ch]);
        assign cmp_evt_a = !cap_mode_a && (cc_a == counter);
        assign cmp_evt_b = !cap_mode_b && (cc_b == counter);
        assign evt_a = cap_evt_a | cmp_evt_a;
        assign evt_b = cap_evt_b | cmp_evt_b;

        // Internal sources tick on divided-clock falling edges, external on the chosen edges.
        always_comb begin
            if (!clk_sel[2]) begin
                clk_tick = int_tick[clk_sel[1:0]];
            end else if (edge_sel[1]) begin
                clk_tick = ext_rise[clk_sel[1:0]] | ext_fall[clk_sel[1:0]];
            end else if (edge_sel[0]) begin
                clk_tick = ext_fall[clk_sel[1:0]];
            end else begin
                clk_tick = ext_rise[clk_sel[1:0]];
            end
        end

        assign phase_mode = (ch == tcc_pkg::TCC_PHASE_CHANNEL) && phase_count_enable_i;
        assign count_tick = chan_cfg_i[ch].count_start
                            && (phase_mode ? phase_step_i : clk_tick);

        always_comb begin
            unique case (clr_src)
                tcc_pkg::TCC_CLR_NONE: clear = 1'b0;
                tcc_pkg::TCC_CLR_A: clear = evt_a;
                tcc_pkg::TCC_CLR_B: clear = evt_b;
                tcc_pkg::TCC_CLR_SYNC: clear = chan_cfg_i[ch].sync_clear;
            endcase
        end

        always_ff @(posedge clk_i) begin
            if (init) begin
                control <= tcc_pkg::TCC_CONTROL_RESET[6:0];
            end else if (wr_ctrl && bus_req_i.be[0]) begin
                control <= bus_req_i.wdata[6:0];
            end
        end

        // Software writes take priority over clearing and counting in the same cycle.
        always_ff @(posedge clk_i) begin
            if (init) begin
                counter <= tcc_pkg::TCC_COUNTER_RESET;
            end else if (wr_cnt) begin
                counter <= merge16(counter, bus_req_i.wdata, bus_req_i.be);
            end else if (clear) begin
                counter <= '0;
            end else if (count_tick) begin
                if (phase_mode && !phase_up_i) begin
                    counter <= counter - 16'h0001;
                end else begin
                    counter <= counter + 16'h0001;
                end
            end
        end

        // A hardware capture or transfer beats a software write in the same cycle.
        always_ff @(posedge clk_i) begin
            if (init) begin
                cc_a <= tcc_pkg::TCC_CC_RESET;
            end else if (cap_evt_a) begin
                cc_a <= counter;
            end else if (buf_en_a && cmp_evt_a) begin
                cc_a <= sb_a_q;
            end else if (wr_a) begin
                cc_a <= merge16(cc_a, bus_req_i.wdata, bus_req_i.be);
            end
        end

        always_ff @(posedge clk_i) begin
            if (init) begin
                cc_b <= tcc_pkg::TCC_CC_RESET;
            end else if (cap_evt_b) begin
                cc_b <= counter;
            end else if (buf_en_b && cmp_evt_b) begin
                cc_b <= sb_b_q;
            end else if (wr_b) begin
                cc_b <= merge16(cc_b, bus_req_i.wdata, bus_req_i.be);
            end
        end

        // An event in the cycle of a clear request wins, so no event is lost.
        always_ff @(posedge clk_i) begin
            if (init) begin
                flag_a[ch] <= 1'b0;
                flag_b[ch] <= 1'b0;
            end else begin
                flag_a[ch] <= evt_a | (flag_a[ch] & ~flag_clear_a_i[ch]);
                flag_b[ch] <= evt_b | (flag_b[ch] & ~flag_clear_b_i[ch]);
            end
        end

        if (ch >= tcc_pkg::TCC_BUF_FIRST) begin : g_buf
            logic [15:0] sb_a;
            logic [15:0] sb_b;
            logic wr_sa;
            logic wr_sb;
            localparam int unsigned EN_A = (ch == 3) ? tcc_pkg::TCC_BUF_EN_A3
                                                     : tcc_pkg::TCC_BUF_EN_A4;
            localparam int unsigned EN_B = (ch == 3) ? tcc_pkg::TCC_BUF_EN_B3
                                                     : tcc_pkg::TCC_BUF_EN_B4;

            assign wr_sa = sel && (bus_req_i.addr[2:0] == tcc_pkg::TCC_OFS_SB_A);
            assign wr_sb = sel && (bus_req_i.addr[2:0] == tcc_pkg::TCC_OFS_SB_B);
            assign buf_en_a = function_control_i[EN_A];
            assign buf_en_b = function_control_i[EN_B];

            always_ff @(posedge clk_i) begin
                if (init) begin
                    sb_a <= tcc_pkg::TCC_SB_RESET;
                end else if (buf_en_a && cap_evt_a) begin
                    sb_a <= cc_a;
                end else if (wr_sa) begin
                    sb_a <= merge16(sb_a, bus_req_i.wdata, bus_req_i.be);
                end
            end

            always_ff @(posedge clk_i) begin
                if (init) begin
                    sb_b <= tcc_pkg::TCC_SB_RESET;
                end else if (buf_en_b && cap_evt_b) begin
                    sb_b <= cc_b;
                end else if (wr_sb) begin
                    sb_b <= merge16(sb_b, bus_req_i.wdata, bus_req_i.be);
                end
            end

            assign sb_a_q = sb_a;
            assign sb_b_q = sb_b;
        end else begin : g_nobuf
            // Channels without buffers never transfer; their buffer slots read as zero.
            assign buf_en_a = 1'b0;
            assign buf_en_b = 1'b0;
            assign sb_a_q = '0;
            assign sb_b_q = '0;
        end

        assign counter_w[ch] = counter;
        assign cc_a_w[ch] = cc_a;
        assign cc_b_w[ch] = cc_b;
        assign sb_a_w[ch] = sb_a_q;
        assign sb_b_w[ch] = sb_b_q;
        assign control_w[ch] = control;
    end

    // Read path: registered, so data appears one cycle after the read strobe.
    logic [15:0] next_rdata;
    logic [2:0] rd_ch;

    assign rd_ch = bus_req_i.addr[5:3];

    always_comb begin
        next_rdata = '0;
        if (bus_req_i.rd && (rd_ch < 3'(NCH))) begin
            unique case (bus_req_i.addr[2:0])
                tcc_pkg::TCC_OFS_CONTROL: next_rdata = {8'h00, 1'b1, control_w[rd_ch]};
                tcc_pkg::TCC_OFS_COUNTER: next_rdata = counter_w[rd_ch];
                tcc_pkg::TCC_OFS_CC_A: next_rdata = cc_a_w[rd_ch];
                tcc_pkg::TCC_OFS_CC_B: next_rdata = cc_b_w[rd_ch];
                tcc_pkg::TCC_OFS_SB_A: next_rdata = sb_a_w[rd_ch];
                tcc_pkg::TCC_OFS_SB_B: next_rdata = sb_b_w[rd_ch];
                default: next_rdata = '0;
            endcase
            // Byte reads return only the lanes asked for.
            if (!bus_req_i.be[0]) begin
                next_rdata[7:0] = 8'h00;
            end
            if (!bus_req_i.be[1]) begin
                next_rdata[15:8] = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_rdata_o <= '0;
        end else begin
            bus_rdata_o <= next_rdata;
        end
    end

    assign match_capture_flag_a_o = flag_a;
    assign match_capture_flag_b_o = flag_b;

endmodule : tcc_timer

`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the timer compare/capture block.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i;
    logic rst_i;
    logic standby;
    tcc_pkg::tcc_bus_req_t req;
    logic [15:0] rdata;
    tcc_pkg::tcc_chan_cfg_t [4:0] cfg;
    logic [3:0] fc;
    logic pce;
    logic step;
    logic up;
    logic [3:0] ext;
    logic [4:0] cap_a;
    logic [4:0] cap_b;
    logic [4:0] clr_a;
    logic [4:0] clr_b;
    logic [4:0] fl_a;
    logic [4:0] fl_b;
    logic [15:0] d;
    logic [15:0] c1;
    int mismatches;
    int n_tests;
    int cycles;
    int n;
    int div;
    int mx;

    tcc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby), .bus_req_i(req),
        .bus_rdata_o(rdata), .chan_cfg_i(cfg), .function_control_i(fc),
        .phase_count_enable_i(pce), .phase_step_i(step), .phase_up_i(up),
        .ext_clock_in_a_i(ext[0]), .ext_clock_in_b_i(ext[1]), .ext_clock_in_c_i(ext[2]),
        .ext_clock_in_d_i(ext[3]), .capture_in_a_i(cap_a), .capture_in_b_i(cap_b),
        .flag_clear_a_i(clr_a), .flag_clear_b_i(clr_b),
        .match_capture_flag_a_o(fl_a), .match_capture_flag_b_o(fl_b));
    tcc_pin_model i_pins (.clk_i(clk_i), .ext_o(ext), .cap_a_o(cap_a), .cap_b_o(cap_b));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic conclude();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // The whole sequence needs under 2000 cycles; the margin covers the slowest divider.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    task automatic wr(input logic [2:0] c, input logic [2:0] r, input logic [1:0] be,
            input logic [15:0] w);
        @(posedge clk_i) req <= '{1'b0, 1'b1, {c, r}, be, w};
        @(posedge clk_i) req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] c, input logic [2:0] r, input logic [1:0] be);
        @(posedge clk_i) req <= '{1'b1, 1'b0, {c, r}, be, 16'h0000};
        @(posedge clk_i) req.rd <= 1'b0;
        @(negedge clk_i) d = rdata;
    endtask : rd

    task automatic rdc(input logic [2:0] c, input logic [2:0] r, input logic [1:0] be,
            input logic [15:0] exp);
        rd(c, r, be);
        chk(d, exp);
    endtask : rdc

    task automatic wait_flag(input int c, input bit b);
        n = 0;
        // Look only at falling edges, where the flags have settled.
        do begin
            @(negedge clk_i);
            n++;
        end while (n < 3000 && (b ? fl_b[c] : fl_a[c]) !== 1'b1);
    endtask : wait_flag

    initial begin
        rst_i = 1'b1;
        standby = 1'b0;
        req = '0;
        cfg = '0;
        fc = 4'h0;
        pce = 1'b0;
        step = 1'b0;
        up = 1'b1;
        clr_a = 5'h00;
        clr_b = 5'h00;
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            rdc(c[2:0], 3'h0, 2'h3, 16'h0080);
            rdc(c[2:0], 3'h1, 2'h3, 16'h0000);
            rdc(c[2:0], 3'h2, 2'h3, 16'hffff);
            rdc(c[2:0], 3'h3, 2'h3, 16'hffff);
            rdc(c[2:0], 3'h4, 2'h3, (c > 2) ? 16'hffff : 16'h0000);
            rdc(c[2:0], 3'h5, 2'h3, (c > 2) ? 16'hffff : 16'h0000);
        end
        wr(3'h0, 3'h0, 2'h3, 16'h0000);
        rdc(3'h0, 3'h0, 2'h3, 16'h0080);
        wr(3'h0, 3'h0, 2'h1, 16'h007f);
        rdc(3'h0, 3'h0, 2'h3, 16'h00ff);
        wr(3'h1, 3'h2, 2'h3, 16'h1234);
        wr(3'h1, 3'h2, 2'h1, 16'h00ab);
        rdc(3'h1, 3'h2, 2'h3, 16'h12ab);
        wr(3'h1, 3'h2, 2'h2, 16'hcd00);
        rdc(3'h1, 3'h2, 2'h2, 16'hcd00);
        rdc(3'h1, 3'h2, 2'h1, 16'h00ab);
        rdc(3'h1, 3'h2, 2'h3, 16'hcdab);
        wr(3'h2, 3'h4, 2'h3, 16'h1234);
        rdc(3'h2, 3'h4, 2'h3, 16'h0000);
        rdc(3'h5, 3'h2, 2'h3, 16'h0000);
        rdc(3'h0, 3'h6, 2'h3, 16'h0000);
        @(posedge clk_i) cfg[0].count_start <= 1'b1;
        wr(3'h0, 3'h2, 2'h3, 16'h0010);
        for (int s = 0; s < 4; s++) begin
            div = 1 << s;
            wr(3'h0, 3'h0, 2'h1, {13'h0, s[2:0]});
            clr_a[0] <= 1'b1;
            wr(3'h0, 3'h1, 2'h3, 16'h0000);
            @(posedge clk_i) clr_a[0] <= 1'b0;
            wait_flag(0, 1'b0);
            chk({15'h0, n >= 15 * div - 2 && n <= 16 * div + 3}, 16'h0001);
        end
        wr(3'h0, 3'h2, 2'h3, 16'h0003);
        wr(3'h0, 3'h3, 2'h3, 16'h0009);
        for (int k = 1; k < 3; k++) begin
            wr(3'h0, 3'h0, 2'h1, {9'h0, k[1:0], 5'h00});
            wr(3'h0, 3'h1, 2'h3, 16'h0000);
            mx = 0;
            repeat (8) begin
                rd(3'h0, 3'h1, 2'h3);
                if (d > mx) mx = d;
            end
            chk({15'h0, mx <= ((k == 1) ? 3 : 9) && mx > ((k == 1) ? 0 : 3)}, 16'h1);
        end
        @(posedge clk_i) cfg[0].sync_clear <= 1'b1;
        wr(3'h0, 3'h0, 2'h1, 16'h0060);
        rdc(3'h0, 3'h1, 2'h3, 16'h0000);
        @(posedge clk_i) cfg[0] <= '0;
        cfg[1].count_start <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            wr(3'h1, 3'h0, 2'h1, {11'h0, p[1:0], 1'b1, p[1:0]});
            wr(3'h1, 3'h1, 2'h3, 16'h0000);
            i_pins.clk_burst(p, 4);
            repeat (6) @(posedge clk_i);
            rdc(3'h1, 3'h1, 2'h3, (p > 1) ? 16'h0008 : 16'h0004);
        end
        @(posedge clk_i) cfg[1].function_select_a <= 3'h4;
        cfg[1].pwm_mode <= 1'b1;
        wr(3'h1, 3'h0, 2'h1, 16'h0000);
        wr(3'h1, 3'h2, 2'h3, 16'h0020);
        wr(3'h1, 3'h1, 2'h3, 16'h0000);
        wait_flag(1, 1'b0);
        chk({15'h0, fl_a[1]}, 16'h0001);
        @(posedge clk_i) cfg[1] <= '0;
        cfg[2].count_start <= 1'b1;
        pce <= 1'b1;
        wr(3'h2, 3'h0, 2'h1, 16'h0007);
        wr(3'h2, 3'h1, 2'h3, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_i) step <= 1'b1;
            up <= (i < 5);
            @(posedge clk_i) step <= 1'b0;
        end
        rdc(3'h2, 3'h1, 2'h3, 16'h0003);
        @(posedge clk_i) cfg[3] <= '{3'h4, 3'h4, 1'b0, 1'b0, 1'b1};
        fc <= 4'h1;
        wr(3'h3, 3'h2, 2'h3, 16'h5555);
        i_pins.cap_pulse(3, 1'b0);
        rdc(3'h3, 3'h4, 2'h3, 16'h5555);
        chk({15'h0, fl_a[3]}, 16'h0001);
        rd(3'h3, 3'h2, 2'h3);
        c1 = d;
        i_pins.cap_pulse(3, 1'b0);
        rdc(3'h3, 3'h4, 2'h3, c1);
        i_pins.cap_pulse(3, 1'b1);
        rdc(3'h3, 3'h5, 2'h3, 16'hffff);
        chk({15'h0, fl_b[3]}, 16'h0001);
        @(posedge clk_i) cfg[4].count_start <= 1'b1;
        fc <= 4'h8;
        wr(3'h4, 3'h5, 2'h3, 16'h0040);
        wr(3'h4, 3'h3, 2'h3, 16'h0030);
        wr(3'h4, 3'h1, 2'h3, 16'h0000);
        wait_flag(4, 1'b1);
        rdc(3'h4, 3'h3, 2'h3, 16'h0040);
        @(posedge clk_i) standby <= 1'b1;
        repeat (2) @(posedge clk_i);
        standby <= 1'b0;
        rdc(3'h1, 3'h2, 2'h3, 16'hffff);
        rdc(3'h4, 3'h5, 2'h3, 16'hffff);
        rdc(3'h0, 3'h0, 2'h3, 16'h0080);
        conclude();
    end
endmodule : tb

`default_nettype wire

// ### testbench/tcc_pin_model.sv
// Behavioural source for the external clock and capture pins.
`default_nettype none

module tcc_pin_model (
    input wire logic clk_i,
    output logic [3:0] ext_o,
    output logic [4:0] cap_a_o,
    output logic [4:0] cap_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ext_o = 4'h0;
        cap_a_o = 5'h00;
        cap_b_o = 5'h00;
    end
    // Each level lasts three cycles or more, so no edge is lost in the two-flop synchroniser.
    task automatic clk_burst(input int p, input int n);
        repeat (n) begin
            @(posedge clk_i) ext_o[p] <= 1'b1;
            repeat (3) @(posedge clk_i);
            ext_o[p] <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : clk_burst
    task automatic cap_pulse(input int c, input bit b);
        @(posedge clk_i);
        if (b) cap_b_o[c] <= 1'b1;
        else cap_a_o[c] <= 1'b1;
        repeat (4) @(posedge clk_i);
        cap_a_o[c] <= 1'b0;
        cap_b_o[c] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : cap_pulse
endmodule : tcc_pin_model

`default_nettype wire

// ### testbench/tcc_timer_checker.sv
// Port-level assertions for the timer compare/capture block.
`default_nettype none

module tcc_timer_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire tcc_pkg::tcc_bus_req_t bus_req_i,
    input wire logic [15:0] bus_rdata_o,
    input wire logic [4:0] flag_clear_a_i,
    input wire logic [4:0] flag_clear_b_i,
    input wire logic [4:0] match_capture_flag_a_o,
    input wire logic [4:0] match_capture_flag_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [2:0] ch;
    logic [2:0] rg;
    logic rq;
    assign ch = bus_req_i.addr[5:3];
    assign rg = bus_req_i.addr[2:0];
    assign rq = bus_req_i.rd;
    a_rdata_idle: assert property (!rq |=> bus_rdata_o == 16'h0000)
        else $error("read data not zero after an idle cycle");
    a_ctrl_rsvd: assert property (rq && rg == 3'h0 && ch < 3'h5 && bus_req_i.be[0] |=>
        bus_rdata_o[7]) else $error("control bit 7 read as zero");
    a_unmapped_zero: assert property (rq && (ch > 3'h4 || rg > 3'h5) |=>
        bus_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_nobuf_zero: assert property (rq && ch < 3'h3 && rg[2] |=> bus_rdata_o == 16'h0000)
        else $error("buffer read in a channel without buffers");
    a_lane_high: assert property (rq && !bus_req_i.be[1] |=> bus_rdata_o[15:8] == 8'h00)
        else $error("disabled high lane not zero");
    a_lane_low: assert property (rq && !bus_req_i.be[0] |=> bus_rdata_o[7:0] == 8'h00)
        else $error("disabled low lane not zero");
    a_standby_clr: assert property (standby_i ##1 standby_i |->
        (match_capture_flag_a_o | match_capture_flag_b_o) == 5'h00)
        else $error("flags survive standby");
    a_flag_a_hold: assert property (!standby_i |=> ($past(match_capture_flag_a_o)
        & ~$past(flag_clear_a_i) & ~match_capture_flag_a_o) == 5'h00)
        else $error("flag a dropped without a clear");
    a_flag_b_hold: assert property (!standby_i |=> ($past(match_capture_flag_b_o)
        & ~$past(flag_clear_b_i) & ~match_capture_flag_b_o) == 5'h00)
        else $error("flag b dropped without a clear");
endmodule : tcc_timer_checker

bind tcc_timer tcc_timer_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
    .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o), .flag_clear_a_i(flag_clear_a_i),
    .flag_clear_b_i(flag_clear_b_i), .match_capture_flag_a_o(match_capture_flag_a_o),
    .match_capture_flag_b_o(match_capture_flag_b_o));

`default_nettype wire
